// File: design/apwr_pkg.sv
// constants, register indices and types for the active power datapath
// assumes one 100 MHz clock shared by the sample source and register port
package apwr_pkg;
  localparam int DATA_W = 24;
  localparam int ARITH_W = 28;
  localparam int BUS_W = 32;
  localparam int NPH = 3;
  localparam int NCOEF = 13;
  localparam int CNT_W = 16;
  localparam int ACC_FRAC = 16;

  // register indices on the register port
  localparam logic [4:0] IDX_CONFIG = 5'h00;
  localparam logic [4:0] IDX_COMPENSATION_MODE_REGISTER = 5'h01;
  localparam logic [4:0] IDX_LEVEL = 5'h02;
  localparam logic [4:0] IDX_COEF_LAST = 5'h0e;
  localparam logic [4:0] IDX_INST_A = 5'h0f;
  localparam logic [4:0] IDX_INST_LAST = 5'h11;

  // coefficient slots, index minus IDX_LEVEL
  localparam int SLOT_LEVEL = 0;
  localparam int SLOT_TGAIN = 1;
  localparam int SLOT_FGAIN = 4;
  localparam int SLOT_TOFS = 7;
  localparam int SLOT_FOFS = 10;

  localparam int FILTER_SEL_BIT = 1;
  localparam int LINE_FREQ_BIT = 14;
  localparam logic FILTER_SEL_RST = 1'b0;
  localparam logic LINE_FREQ_RST = 1'b0;
  localparam logic [DATA_W-1:0] COEF_RST = 24'h000000;

  // sample period and its length in clock cycles
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SAMPLE_PERIOD_US = 125;
  localparam int SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam int SAMPLE_RATE_HZ = 1000000 / SAMPLE_PERIOD_US;

  // scaling of the multiplier output and of the waveform register
  localparam int PROD_SHIFT = 19;
  localparam int WATT_SHIFT = 4;
  localparam int GAIN_FRAC = 23;
  localparam int FULL_SCALE_POWER = 33516139;

  // filter settling targets; shift is log2 of an eighth of the settling time in samples
  localparam int LPF_STD_SETTLE_MS = 650;
  localparam int LPF_STRONG_SETTLE_MS = 1300;
  localparam int FUND_63_SETTLE_MS = 375;
  localparam int FUND_100_SETTLE_MS = 875;
  localparam logic [3:0] LPF_STD_SHIFT =
    4'($clog2(LPF_STD_SETTLE_MS * SAMPLE_RATE_HZ / 8000));
  localparam logic [3:0] LPF_STRONG_SHIFT =
    4'($clog2(LPF_STRONG_SETTLE_MS * SAMPLE_RATE_HZ / 8000));
  localparam logic [3:0] FUND_50_SHIFT =
    4'($clog2(FUND_63_SETTLE_MS * SAMPLE_RATE_HZ / 8000));
  localparam logic [3:0] FUND_60_SHIFT = FUND_50_SHIFT - 4'h1;

  typedef enum logic [1:0] {APWR_SZ_8, APWR_SZ_16, APWR_SZ_32} apwr_size_e;
endpackage

// File: design/apwr_lpf.sv
// two cascaded first-order low-pass stages recovering the dc of a product
// assumes in_valid pulses at most once every three clock cycles
`timescale 1ns/1ps
`default_nettype none
module apwr_lpf #(
  parameter int W = apwr_pkg::ARITH_W
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic signed [W-1:0] in_data,
  input wire logic [3:0] shift,
  output logic out_valid,
  output logic signed [W-1:0] out_data
);
  import apwr_pkg::*;
  localparam int AW = W + ACC_FRAC;

  typedef struct packed {
    logic signed [AW-1:0] s1;
    logic signed [AW-1:0] s2;
    logic [1:0] vld;
  } apwr_lpf_s;

  apwr_lpf_s st_r, st_nxt;
  logic signed [AW:0] d1, d2;

  // fractional bits keep small steps from stalling in a dead band
  assign d1 = {in_data[W-1], in_data, {ACC_FRAC{1'b0}}} - {st_r.s1[AW-1], st_r.s1};
  assign d2 = {st_r.s1[AW-1], st_r.s1} - {st_r.s2[AW-1], st_r.s2};

  always_comb begin
    st_nxt = st_r;
    st_nxt.vld = {st_r.vld[0], in_valid};
    if (in_valid) begin
      st_nxt.s1 = st_r.s1 + AW'(d1 >>> shift);
    end
    if (st_r.vld[0]) begin
      st_nxt.s2 = st_r.s2 + AW'(d2 >>> shift);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_valid = st_r.vld[1];
  assign out_data = st_r.s2[AW-1:ACC_FRAC];

  lpf_latency_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_valid |-> ##2 out_valid) else $error("filter output late");
  lpf_track_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_valid && (d1 > 0) |=> st_r.s1 >= $past(st_r.s1))
    else $error("filter moved away from input");
endmodule // apwr_lpf
`default_nettype wire

// File: design/apwr_scale.sv
// gain and offset correction of one filtered power, plus waveform value
// assumes gain and offset are held stable for the whole sample period
`timescale 1ns/1ps
`default_nettype none
module apwr_scale (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic enable,
  input wire logic signed [apwr_pkg::ARITH_W-1:0] in_data,
  input wire logic signed [apwr_pkg::DATA_W-1:0] gain,
  input wire logic signed [apwr_pkg::DATA_W-1:0] offset,
  output logic out_valid,
  output logic signed [apwr_pkg::ARITH_W-1:0] power_full,
  output logic [apwr_pkg::DATA_W-1:0] inst_power
);
  import apwr_pkg::*;
  localparam int PW = ARITH_W + DATA_W;

  typedef struct packed {
    logic vld;
    logic signed [ARITH_W-1:0] full;
  } apwr_scale_s;

  apwr_scale_s st_r, st_nxt;
  logic signed [PW-1:0] prod;
  logic signed [ARITH_W-1:0] scaled, corrected;

  assign prod = in_data * gain;
  // wraps silently on overflow: no flag exists to report it
  assign scaled = in_data + ARITH_W'(prod >>> GAIN_FRAC);
  assign corrected = scaled + ARITH_W'(offset);

  always_comb begin
    st_nxt = st_r;
    st_nxt.vld = in_valid;
    if (in_valid) begin
      st_nxt.full = enable ? corrected : '0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out_valid = st_r.vld;
  assign power_full = st_r.full;
  assign inst_power = st_r.full[WATT_SHIFT+DATA_W-1:WATT_SHIFT];

  gain_scale_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_valid && enable && offset == '0 |=> power_full ==
      ARITH_W'($past(in_data) + ($past(prod) >>> GAIN_FRAC)))
    else $error("gain scaling wrong");
  offset_add_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_valid && enable && gain == '0 |=> power_full ==
      ARITH_W'($past(in_data) + $past(offset)))
    else $error("offset not added");
  disabled_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_valid && !enable |=> out_valid && power_full == '0)
    else $error("disabled path not zero");
  half_gain_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    in_valid && enable && gain == 24'hc00000);
endmodule // apwr_scale
`default_nettype wire

// File: design/apwr_datapath.sv
// three-phase active power datapath: multiply, filter, gain and offset
// Behaviour
// - multiply v and i, low-pass to dc
// - config bit 1 picks filter strength
// - waveform value is scaled power over sixteen
// - 24-bit waveform registers readable per phase
// - compensation_mode_register bit 14 selects 50 or 60 Hz
// - level read sign-extended to 28 bits
// - fundamental path settles within set times
// - power times one plus gain over 2^23
// - 0xc00000 halves, 0x400000 adds half
// - separate gain per phase and path
// - signed offset per phase and type
// - gain/offset words sign-extended, 8/16/32-bit
// - new result every 125 us
// assumes ADC samples arrive on clk_sys and are valid when sample_tick pulses
`timescale 1ns/1ps
`default_nettype none
module apwr_datapath #(
  parameter int SAMPLE_CYCLES = apwr_pkg::SAMPLE_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic signed [apwr_pkg::DATA_W-1:0] v_a_smp,
  input wire logic signed [apwr_pkg::DATA_W-1:0] v_b_smp,
  input wire logic signed [apwr_pkg::DATA_W-1:0] v_c_smp,
  input wire logic signed [apwr_pkg::DATA_W-1:0] i_a_smp,
  input wire logic signed [apwr_pkg::DATA_W-1:0] i_b_smp,
  input wire logic signed [apwr_pkg::DATA_W-1:0] i_c_smp,
  input wire logic [4:0] reg_addr,
  input wire apwr_pkg::apwr_size_e reg_size,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [apwr_pkg::BUS_W-1:0] reg_wdata,
  output logic [apwr_pkg::BUS_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  output logic sample_tick,
  output logic power_valid,
  output logic [apwr_pkg::DATA_W-1:0] fund_inst_a,
  output logic [apwr_pkg::DATA_W-1:0] fund_inst_b,
  output logic [apwr_pkg::DATA_W-1:0] fund_inst_c
);
  import apwr_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] tick_cnt;
    logic tick;
    logic lpf_strong;
    logic freq_60;
    logic [NCOEF-1:0][DATA_W-1:0] coef;
    logic [NCOEF-1:0][DATA_W-1:0] shadow;
    logic [NPH-1:0][ARITH_W-1:0] prod;
    logic prod_valid;
    logic [BUS_W-1:0] rdata;
    logic rd_valid;
  } apwr_state_s;

  apwr_state_s st_r, st_nxt;

  logic [NPH-1:0][DATA_W-1:0] v_w, i_w;
  logic [NPH-1:0][ARITH_W-1:0] prod_w;
  logic [NPH-1:0][ARITH_W-1:0] tot_filt, fund_filt;
  logic [NPH-1:0][DATA_W-1:0] tot_inst, fund_inst;
  logic [NPH-1:0] tot_vld, fund_vld, tot_out_vld, fund_out_vld;
  logic [4:0] slot_w;
  logic fund_en;
  logic [3:0] tot_shift, fund_shift;

  assign v_w = {v_c_smp, v_b_smp, v_a_smp};
  assign i_w = {i_c_smp, i_b_smp, i_a_smp};
  assign slot_w = reg_addr - IDX_LEVEL;

  assign tot_shift = st_r.lpf_strong ? LPF_STRONG_SHIFT : LPF_STD_SHIFT;
  // the fundamental filter follows the line frequency setting
  assign fund_shift = st_r.freq_60 ? FUND_60_SHIFT : FUND_50_SHIFT;
  // without a positive level the fundamental output is held at zero
  assign fund_en = !st_r.shadow[SLOT_LEVEL][DATA_W-1] &&
    (st_r.shadow[SLOT_LEVEL] != '0);

  function automatic logic [DATA_W-1:0] merge24(
    input logic [DATA_W-1:0] old,
    input logic [BUS_W-1:0] wd,
    input apwr_size_e sz
  );
    logic [DATA_W-1:0] r;
    r = wd[DATA_W-1:0];
    case (sz)
      APWR_SZ_8: r = {old[23:8], wd[7:0]};
      APWR_SZ_16: r = {old[23:16], wd[15:0]};
      default: r = wd[DATA_W-1:0];
    endcase
    return r;
  endfunction

  function automatic logic [BUS_W-1:0] ext32(input logic [DATA_W-1:0] c);
    return {4'h0, {4{c[DATA_W-1]}}, c};
  endfunction

  generate
    for (genvar ph = 0; ph < NPH; ph++) begin : g_phase
      logic signed [2*DATA_W-1:0] mult;
      assign mult = $signed(v_w[ph]) * $signed(i_w[ph]);
      assign prod_w[ph] = mult[PROD_SHIFT+ARITH_W-1:PROD_SHIFT];

      apwr_lpf #(.W(ARITH_W)) u_tot_lpf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(st_r.prod_valid),
        .in_data(st_r.prod[ph]),
        .shift(tot_shift),
        .out_valid(tot_vld[ph]),
        .out_data(tot_filt[ph])
      );
      apwr_lpf #(.W(ARITH_W)) u_fund_lpf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(st_r.prod_valid),
        .in_data(st_r.prod[ph]),
        .shift(fund_shift),
        .out_valid(fund_vld[ph]),
        .out_data(fund_filt[ph])
      );
      // each phase and path reads its own gain and offset slots; the fundamental paths also share the level slot
      apwr_scale u_tot_scale (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(tot_vld[ph]),
        .enable(1'b1),
        .in_data(tot_filt[ph]),
        .gain(st_r.shadow[SLOT_TGAIN+ph]),
        .offset(st_r.shadow[SLOT_TOFS+ph]),
        .out_valid(tot_out_vld[ph]),
        .power_full(),
        .inst_power(tot_inst[ph])
      );
      apwr_scale u_fund_scale (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(fund_vld[ph]),
        .enable(fund_en),
        .in_data(fund_filt[ph]),
        .gain(st_r.shadow[SLOT_FGAIN+ph]),
        .offset(st_r.shadow[SLOT_FOFS+ph]),
        .out_valid(fund_out_vld[ph]),
        .power_full(),
        .inst_power(fund_inst[ph])
      );
    end
  endgenerate

  always_comb begin
    logic [BUS_W-1:0] img;
    img = '0;
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.prod_valid = 1'b0;
    st_nxt.rd_valid = reg_rd_en;
    if (st_r.tick_cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
    end
    if (st_r.tick) begin
      // coefficients are latched once per sample so a write never splits one
      st_nxt.shadow = st_r.coef;
      st_nxt.prod = prod_w;
      st_nxt.prod_valid = 1'b1;
    end
    if (reg_wr_en) begin
      if (reg_addr == IDX_CONFIG) begin
        st_nxt.lpf_strong = reg_wdata[FILTER_SEL_BIT];
      end
      if (reg_addr == IDX_COMPENSATION_MODE_REGISTER && reg_size != APWR_SZ_8) begin
        st_nxt.freq_60 = reg_wdata[LINE_FREQ_BIT];
      end
      if (reg_addr >= IDX_LEVEL && reg_addr <= IDX_COEF_LAST) begin
        st_nxt.coef[slot_w[3:0]] =
          merge24(st_r.coef[slot_w[3:0]], reg_wdata, reg_size);
      end
    end
    if (reg_rd_en) begin
      if (reg_addr == IDX_CONFIG) begin
        img[FILTER_SEL_BIT] = st_r.lpf_strong;
      end else if (reg_addr == IDX_COMPENSATION_MODE_REGISTER) begin
        img[LINE_FREQ_BIT] = st_r.freq_60;
      end else if (reg_addr >= IDX_LEVEL && reg_addr <= IDX_COEF_LAST) begin
        img = ext32(st_r.coef[slot_w[3:0]]);
      end else if (reg_addr >= IDX_INST_A && reg_addr <= IDX_INST_LAST) begin
        img = {8'h00, tot_inst[reg_addr - IDX_INST_A]};
      end
      case (reg_size)
        APWR_SZ_8: st_nxt.rdata = img & 32'h000000ff;
        APWR_SZ_16: st_nxt.rdata = img & 32'h0000ffff;
        default: st_nxt.rdata = img;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.lpf_strong <= FILTER_SEL_RST;
      st_r.freq_60 <= LINE_FREQ_RST;
      st_r.coef <= {NCOEF{COEF_RST}};
      st_r.shadow <= {NCOEF{COEF_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rd_valid = st_r.rd_valid;
  assign sample_tick = st_r.tick;
  assign power_valid = tot_out_vld[0];
  assign fund_inst_a = fund_inst[0];
  assign fund_inst_b = fund_inst[1];
  assign fund_inst_c = fund_inst[2];

  // helper: cycles since the previous sample tick
  int gap_cnt;
  logic seen_tick;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt <= 0;
      seen_tick <= 1'b0;
    end else begin
      gap_cnt <= st_r.tick ? 0 : gap_cnt + 1;
      seen_tick <= seen_tick | st_r.tick;
    end
  end

  tick_period_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r.tick && seen_tick |-> gap_cnt == SAMPLE_CYCLES - 1)
    else $error("sample period wrong");
  prod_capture_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r.tick |=> st_r.prod_valid && st_r.prod == $past(prod_w))
    else $error("product not captured at tick");
  filter_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr_en && reg_addr == IDX_CONFIG |=>
      tot_shift == ($past(reg_wdata[FILTER_SEL_BIT]) ?
        LPF_STRONG_SHIFT : LPF_STD_SHIFT))
    else $error("filter strength not applied");
  line_freq_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr_en && reg_addr == IDX_COMPENSATION_MODE_REGISTER && reg_size == APWR_SZ_32 |=>
      st_r.freq_60 == $past(reg_wdata[LINE_FREQ_BIT]))
    else $error("line frequency bit not stored");
  coef_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd_en && reg_size == APWR_SZ_32 && reg_addr >= IDX_LEVEL &&
      reg_addr <= IDX_COEF_LAST |=> reg_rd_valid &&
      reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}})
    else $error("coefficient word not sign extended");
  shadow_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !st_r.tick |=> $stable(st_r.shadow))
    else $error("coefficients changed mid sample");
  unmapped_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd_en && reg_addr > IDX_INST_LAST |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  power_flow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r.tick |-> ##4 power_valid)
    else $error("power result missing after tick");
  // every phase and both paths must deliver in the same cycle
  phase_align_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tot_out_vld == {NPH{power_valid}} && fund_out_vld == tot_out_vld)
    else $error("phase results out of step");

  tick_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    st_r.tick && seen_tick);
  strong_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    st_r.lpf_strong && power_valid);
  fund_on_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    fund_en && fund_out_vld[0]);
  full_scale_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    power_valid && $signed(tot_filt[0]) > (FULL_SCALE_POWER / 2));
endmodule // apwr_datapath
`default_nettype wire

// File: verification/test_apwr_datapath.sv
// self-checking bench for the three-phase active power datapath
// assumes the datapath top runs with a shortened sample period of 8 cycles
`timescale 1ns/1ps
`default_nettype none
module test_apwr_datapath;
  import apwr_pkg::*;
  localparam int SC = 8;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic signed [DATA_W-1:0] v_smp = '0;
  logic signed [DATA_W-1:0] i_smp = '0;
  logic [4:0] reg_addr = '0;
  apwr_size_e reg_size = APWR_SZ_32;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [BUS_W-1:0] reg_wdata = '0;
  logic [BUS_W-1:0] reg_rdata;
  logic reg_rd_valid;
  logic sample_tick;
  logic power_valid;
  logic [DATA_W-1:0] fund_inst_a, fund_inst_b, fund_inst_c;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int gap = 0;
  logic [4:0] tick_sr = '0;
  logic [31:0] seed = 32'h00000036;
  logic [DATA_W-1:0] shadow [2:14];
  logic [DATA_W-1:0] fund [0:2];
  logic [BUS_W-1:0] rd;
  logic [BUS_W-1:0] inst [0:2];
  logic [DATA_W-1:0] d;

  always #5 clk_sys = ~clk_sys;

  apwr_datapath #(.SAMPLE_CYCLES(SC)) apwr_datapath_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .v_a_smp(v_smp), .v_b_smp(v_smp), .v_c_smp(v_smp),
    .i_a_smp(i_smp), .i_b_smp(i_smp), .i_c_smp(i_smp),
    .reg_addr(reg_addr), .reg_size(reg_size), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .sample_tick(sample_tick),
    .power_valid(power_valid), .fund_inst_a(fund_inst_a),
    .fund_inst_b(fund_inst_b), .fund_inst_c(fund_inst_c)
  );

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // 32-bit view of a signed 24-bit coefficient
  function automatic logic [31:0] cx(input logic [23:0] v);
    return {4'h0, {4{v[23]}}, v};
  endfunction

  function automatic logic [31:0] near(input int x, input int y);
    return {31'h0, (x - y) <= 2 && (y - x) <= 2};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] ad, input apwr_size_e sz,
                    input logic [31:0] dt);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_size <= sz;
    reg_wdata <= dt;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rdreg(input logic [4:0] ad, input apwr_size_e sz);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_size <= sz;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(negedge clk_sys);
    check({31'h0, reg_rd_valid}, 32'h1);
    rd = reg_rdata;
  endtask

  task automatic wait_pv(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      while (power_valid !== 1'b1) @(negedge clk_sys);
    end
    fund[0] = fund_inst_a;
    fund[1] = fund_inst_b;
    fund[2] = fund_inst_c;
  endtask

  // inst registers hold for a whole sample, so three reads fit after a pulse
  task automatic read_inst();
    for (int p = 0; p < 3; p++) begin
      rdreg(IDX_INST_A + 5'(p), APWR_SZ_32);
      inst[p] = rd;
    end
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles > 6000) begin
      err_total = err_total + 1;
      stop_test();
    end
    tick_sr <= {tick_sr[3:0], sample_tick};
    if (sample_tick === 1'b1) begin
      if (gap != 0) check(32'(gap), 32'(SC));
      gap <= 1;
    end else if (gap != 0) begin
      gap <= gap + 1;
    end
    if (!sys_rst) check({31'h0, power_valid}, {31'h0, tick_sr[3]});
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int k = 0; k < 18; k++) begin
      rdreg(5'(k), APWR_SZ_32);
      check(rd, 32'h0);
    end
    rdreg(5'h1f, APWR_SZ_32);
    check(rd, 32'h0);
    wr(IDX_INST_A, APWR_SZ_32, 32'hffffffff);
    rdreg(IDX_INST_A, APWR_SZ_32);
    check(rd, 32'h0);
    wr(IDX_CONFIG, APWR_SZ_32, 32'hffffffff);
    rdreg(IDX_CONFIG, APWR_SZ_32);
    check(rd, 32'h1 << FILTER_SEL_BIT);
    wr(IDX_COMPENSATION_MODE_REGISTER, APWR_SZ_32, 32'hffffffff);
    wr(IDX_COMPENSATION_MODE_REGISTER, APWR_SZ_8, 32'h0);
    rdreg(IDX_COMPENSATION_MODE_REGISTER, APWR_SZ_32);
    check(rd, 32'h1 << LINE_FREQ_BIT);
    wr(IDX_COMPENSATION_MODE_REGISTER, APWR_SZ_16, 32'h0);
    rdreg(IDX_COMPENSATION_MODE_REGISTER, APWR_SZ_32);
    check(rd, 32'h0);
    // random coefficients, full then partial-width words
    for (int k = 2; k < 15; k++) begin
      seed = nxt(seed);
      shadow[k] = (k == 3) ? 24'hc00000 : seed[23:0];
      wr(5'(k), APWR_SZ_32, {seed[31:24], shadow[k]});
      rdreg(5'(k), APWR_SZ_32);
      check(rd, cx(shadow[k]));
      seed = nxt(seed);
      shadow[k][15:0] = seed[15:0];
      wr(5'(k), APWR_SZ_16, seed);
      rdreg(5'(k), APWR_SZ_16);
      check(rd, cx(shadow[k]) & 32'hffff);
      seed = nxt(seed);
      shadow[k][7:0] = seed[7:0];
      wr(5'(k), APWR_SZ_8, seed);
      rdreg(5'(k), APWR_SZ_8);
      check(rd, cx(shadow[k]) & 32'hff);
      rdreg(5'(k), APWR_SZ_32);
      check(rd, cx(shadow[k]));
    end
    // zero samples: outputs are the offsets alone, fundamental gated by level
    wait_pv(2);
    read_inst();
    for (int p = 0; p < 3; p++) begin
      d = shadow[SLOT_TOFS + 2 + p];
      check(inst[p], {8'h00, {4{d[23]}}, d[23:4]});
      d = shadow[SLOT_FOFS + 2 + p];
      if (shadow[2][23] || shadow[2] == 24'h0) d = 24'h0;
      else d = {{4{d[23]}}, d[23:4]};
      check({8'h00, fund[p]}, {8'h00, d});
    end
    // phase a unity, b plus half, c minus half, on both paths
    for (int k = 2; k < 15; k++) begin
      d = (k == 4 || k == 7) ? 24'h400000 : 24'h000000;
      if (k == 5 || k == 8) d = 24'hc00000;
      wr(5'(k), APWR_SZ_32, {8'h00, d});
    end
    seed = nxt(seed);
    v_smp <= {2'b01, seed[21:0]};
    i_smp <= 24'sh400000;
    wait_pv(60);
    check({8'h00, fund[0]}, 32'h0);
    wr(IDX_LEVEL, APWR_SZ_32, 32'h00078000);
    wait_pv(60);
    read_inst();
    check({31'h0, int'(inst[0]) > 64}, 32'h1);
    check(inst[0][31:24], 8'h00);
    check(near(int'(inst[1]), int'(inst[0]) * 3 / 2), 32'h1);
    check(near(int'(inst[2]), int'(inst[0]) / 2), 32'h1);
    check({31'h0, int'(fund[0]) > 0}, 32'h1);
    check(near(int'(fund[1]), int'(fund[0]) * 3 / 2), 32'h1);
    check(near(int'(fund[2]), int'(fund[0]) / 2), 32'h1);
    stop_test();
  end
endmodule // test_apwr_datapath
`default_nettype wire
